/* File: src/emc_pkg.sv */
// constants shared by the external memory area configuration block
// assumes a 32-bit ahb-lite register port and eight chip select areas
package emc_pkg;

   // ----------------------------------------------------------------
   // register indices as printed; byte address is index times four
   // ----------------------------------------------------------------
   localparam logic [31:0] IDX_AREA_CFG_LO  = 32'hfffff480;
   localparam logic [31:0] IDX_AREA_CFG_HI  = 32'hfffff482;
   localparam logic [31:0] IDX_SETUP_WAIT   = 32'hfffff48a;
   localparam logic [31:0] IDX_BUS_WIDTH    = 32'hfffff48e;
   localparam logic [31:0] IDX_BUS_MODE     = 32'hfffff498;
   localparam int          ADDR_SHIFT       = 2;

   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int          NUM_AREAS        = 8;
   localparam int          AREAS_PER_CFG    = 4;
   localparam int          CFG_GROUP_W      = 4;
   localparam int          CFG_ENABLE_POS   = 3;
   localparam int          CFG_TYPE_POS     = 0;
   localparam int          SETUP_FIELD_W    = 2;
   localparam int          WIDTH_FIELD_W    = 2;
   localparam int          LOW_POWER_POS    = 2;
   localparam int          CLK_SEL_POS      = 0;
   localparam logic [15:0] AREA_CFG_MASK    = 16'h9999;
   localparam logic [7:0]  BUS_MODE_MASK    = 8'h05;
   localparam logic [15:0] AREA_CFG_RST     = 16'h0000;
   localparam logic [15:0] SETUP_WAIT_RST   = 16'hffff;
   localparam logic [15:0] BUS_WIDTH_RST    = 16'haaaa;
   localparam logic [7:0]  BUS_MODE_RST     = 8'h00;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [1:0]  WIDTH_8          = 2'h0;
   localparam logic [1:0]  WIDTH_16         = 2'h1;
   localparam logic [1:0]  WIDTH_32         = 2'h2;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

   typedef enum logic [1:0] {
      EMC_IDLE   = 2'h0,
      EMC_SETUP  = 2'h1,
      EMC_ACCESS = 2'h3,
      EMC_END    = 2'h2
   } emc_state_t;

endpackage

/* File: src/emc_wait_cnt.sv */
// down counter for address setup wait states
// assumes load and decrement are never asked for in the same cycle
`timescale 1ns/1ps
module emc_wait_cnt #(
   parameter int W = 2
) (
   input  wire logic         i_mclk,   // memory interface clock
   input  wire logic         i_srst,   // synchronous reset, high
   input  wire logic         i_load,   // load a new count
   input  wire logic [W-1:0] i_count,  // count to load
   input  wire logic         i_dec,    // step down by one
   output logic              o_last    // one wait left or none
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   localparam logic [W-1:0] ONE = W'(1);

   assign cnt_d  = i_load ? i_count : (i_dec ? cnt_q - ONE : cnt_q);
   assign o_last = (cnt_q <= ONE);

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

/* File: src/emc_area_cfg.sv */
// area configuration and setup wait sequencing of the external memory controller
// assumes one ahb-lite master, word accesses, and a stall pin from outside the clock domain
//
// Summary of operation
// R1: each area has an enable bit, 0 disables and 1 enables controller operation for it.
// R2: each area has a device type bit, 0 for sram or external i/o and 1 for page rom.
// R3: the low config register holds areas 0-3, the high one areas 4-7, enable on top, type at bottom of each nibble.
// R4: software writes zero to reserved bits of the config registers.
// R5: software sets the config registers up after reset before external accesses and leaves them alone.
// R6: setting low power clears all device type bits, keeps enables and stops the bus clock.
// R7: clearing low power clears all enable bits and restarts the bus clock, leaving both config registers zero.
// R8: each area has a two-bit bus width field, 00 8-bit, 01 16-bit, 10 32-bit, 11 prohibited.
// R9: each area inserts 0 to 3 setup waits from its field between address setup and the first access state.
// R10: setup waits apply only to sram or page rom accesses.
// R11: after reset every area inserts three setup waits until reprogrammed.
// R12: the external stall pin is ignored during setup waits.
// R13: internal memory accesses ignore the setup settings and get no setup waits.
// R14: software programs the setup register first and never changes it during an external access.
// R15: low power stops the memory interface and drives its outputs inactive.
// R16: no external bus cycle is made for an area whose enable is 0.
`timescale 1ns/1ps
module emc_area_cfg
   import emc_pkg::*;
(
   input  wire logic        i_mclk,        // memory interface clock, 25 mhz
   input  wire logic        i_srst,        // synchronous reset, high
   input  wire logic        i_hsel,        // ahb slave select
   input  wire logic [31:0] i_haddr,       // ahb address
   input  wire logic [1:0]  i_htrans,      // ahb transfer type
   input  wire logic        i_hwrite,      // ahb write
   input  wire logic [2:0]  i_hsize,       // ahb size
   input  wire logic [31:0] i_hwdata,      // ahb write data
   input  wire logic        i_hready,      // ahb bus ready
   output logic      [31:0] o_hrdata,      // ahb read data
   output logic             o_hreadyout,   // ahb slave ready
   output logic             o_hresp,       // ahb response, always okay
   input  wire logic        i_acc_req,     // access request, level
   input  wire logic [2:0]  i_acc_area,    // area of the access
   input  wire logic        i_acc_internal,// access to internal memory
   input  wire logic        i_acc_io,      // access to external i/o
   input  wire logic        i_stall_pin,   // external stall pin, async
   output logic      [7:0]  o_cs_n,        // chip selects, low active
   output logic             o_first_access,// in first access state
   output logic             o_acc_done,    // access finished, pulse
   output logic             o_acc_reject,  // access refused, pulse
   output logic      [1:0]  o_bus_width,   // width of current area
   output logic             o_page_rom,    // current area is page rom
   output logic             o_bus_clk_en,  // bus clock running
   output logic             o_clk_half     // bus clock select
);

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [15:0] cfg_lo_q, cfg_hi_q, setup_q, width_q;
   logic [7:0]  mode_q;
   logic        wr_pend_q;
   logic [31:0] wr_addr_q;
   logic [31:0] rdata_d;
   logic        addr_ph;

   localparam logic [31:0] A_CFG_LO = IDX_AREA_CFG_LO << ADDR_SHIFT;
   localparam logic [31:0] A_CFG_HI = IDX_AREA_CFG_HI << ADDR_SHIFT;
   localparam logic [31:0] A_SETUP  = IDX_SETUP_WAIT  << ADDR_SHIFT;
   localparam logic [31:0] A_WIDTH  = IDX_BUS_WIDTH   << ADDR_SHIFT;
   localparam logic [31:0] A_MODE   = IDX_BUS_MODE    << ADDR_SHIFT;

   assign addr_ph = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);

   wire rd_cfg_lo = (i_haddr == A_CFG_LO);
   wire rd_cfg_hi = (i_haddr == A_CFG_HI);
   wire rd_setup  = (i_haddr == A_SETUP);
   wire rd_width  = (i_haddr == A_WIDTH);
   wire rd_mode   = (i_haddr == A_MODE);

   assign rdata_d = rd_cfg_lo ? {16'h0000, cfg_lo_q} :
                    rd_cfg_hi ? {16'h0000, cfg_hi_q} :
                    rd_setup  ? {16'h0000, setup_q}  :
                    rd_width  ? {16'h0000, width_q}  :
                    rd_mode   ? {24'h000000, mode_q} : 32'h00000000;

   wire wr_cfg_lo = wr_pend_q & (wr_addr_q == A_CFG_LO);
   wire wr_cfg_hi = wr_pend_q & (wr_addr_q == A_CFG_HI);
   wire wr_setup  = wr_pend_q & (wr_addr_q == A_SETUP);
   wire wr_width  = wr_pend_q & (wr_addr_q == A_WIDTH);
   wire wr_mode   = wr_pend_q & (wr_addr_q == A_MODE);

   // reserved bits are kept at zero even if software breaks the rule
   wire [15:0] wcfg  = i_hwdata[15:0] & AREA_CFG_MASK;  // R4
   wire [7:0]  wmode = i_hwdata[7:0] & BUS_MODE_MASK;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= '0;
         o_hrdata    <= '0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         wr_pend_q   <= addr_ph & i_hwrite;
         wr_addr_q   <= i_haddr;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (addr_ph & ~i_hwrite) begin
            o_hrdata <= rdata_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // low power entry and exit
   // ----------------------------------------------------------------
   wire lp_now   = mode_q[LOW_POWER_POS];
   wire lp_next  = wr_mode ? wmode[LOW_POWER_POS] : lp_now;
   wire lp_enter = ~lp_now & lp_next;
   wire lp_exit  = lp_now & ~lp_next;

   // type bits sit at the bottom of every nibble, enables at the top
   localparam logic [15:0] TYPE_BITS = 16'h1111 << CFG_TYPE_POS;
   localparam logic [15:0] EN_BITS   = 16'h1111 << CFG_ENABLE_POS;

   wire [15:0] cfg_lo_w = wr_cfg_lo ? wcfg : cfg_lo_q;
   wire [15:0] cfg_hi_w = wr_cfg_hi ? wcfg : cfg_hi_q;
   wire [15:0] lp_keep  = lp_enter ? ~TYPE_BITS : (lp_exit ? ~EN_BITS : 16'hffff);  // R6 R7

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cfg_lo_q <= AREA_CFG_RST;
         cfg_hi_q <= AREA_CFG_RST;
         setup_q  <= SETUP_WAIT_RST;  // R11
         width_q  <= BUS_WIDTH_RST;
         mode_q   <= BUS_MODE_RST;
      end else begin
         cfg_lo_q <= cfg_lo_w & lp_keep;  // R3 R6 R7
         cfg_hi_q <= cfg_hi_w & lp_keep;  // R3 R6 R7
         if (wr_setup) begin
            setup_q <= i_hwdata[15:0];
         end
         if (wr_width) begin
            width_q <= i_hwdata[15:0];  // R8
         end
         if (wr_mode) begin
            mode_q <= wmode;
         end
      end
   end

   // ----------------------------------------------------------------
   // per-area field selection
   // ----------------------------------------------------------------
   wire [31:0] cfg_all = {cfg_hi_q, cfg_lo_q};
   wire [3:0]  nib     = cfg_all[i_acc_area * CFG_GROUP_W +: CFG_GROUP_W];
   wire        sel_en  = nib[CFG_ENABLE_POS];  // R1
   wire        sel_rom = nib[CFG_TYPE_POS];  // R2
   wire [1:0]  sel_wid = width_q[i_acc_area * WIDTH_FIELD_W +: WIDTH_FIELD_W];  // R8
   wire [1:0]  sel_set = setup_q[i_acc_area * SETUP_FIELD_W +: SETUP_FIELD_W];  // R9

   // internal or i/o accesses get no setup waits
   wire [1:0]  waits   = (i_acc_internal | i_acc_io) ? 2'h0 : sel_set;  // R10 R13

   // ----------------------------------------------------------------
   // stall pin synchroniser
   // ----------------------------------------------------------------
   logic stall_m_q, stall_s_q;
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         stall_m_q <= 1'b0;
         stall_s_q <= 1'b0;
      end else begin
         stall_m_q <= i_stall_pin;
         stall_s_q <= stall_m_q;
      end
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   emc_state_t state_q, state_d;
   logic       ext_q;
   logic [2:0] area_q;
   logic       cnt_last;

   wire take   = (state_q == EMC_IDLE) & i_acc_req;
   wire refuse = take & ~i_acc_internal & (~sel_en | lp_now);  // R16 R15
   wire go     = take & ~refuse;

   emc_wait_cnt #(
      .W (SETUP_FIELD_W)
   ) u_wait (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_load  (go),
      .i_count (waits),
      .i_dec   (state_q == EMC_SETUP),
      .o_last  (cnt_last)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         EMC_IDLE: begin
            if (go) begin
               state_d = (waits == 2'h0) ? EMC_ACCESS : EMC_SETUP;  // R9
            end
         end
         EMC_SETUP: begin
            // stall pin deliberately not looked at here
            if (cnt_last) begin
               state_d = EMC_ACCESS;  // R12
            end
         end
         EMC_ACCESS: begin
            if (~stall_s_q) begin
               state_d = EMC_END;
            end
         end
         EMC_END: begin
            state_d = EMC_IDLE;
         end
         default: begin
            state_d = EMC_IDLE;
         end
      endcase
      if (lp_now) begin
         state_d = EMC_IDLE;  // R15
      end
   end

   wire ext_active = ext_q & ((state_d == EMC_SETUP) | (state_d == EMC_ACCESS));
   wire ext_next   = go ? ~i_acc_internal : ext_q;
   wire [2:0] area_next = go ? i_acc_area : area_q;
   wire [7:0] cs_n_d = (ext_next & ((state_d == EMC_SETUP) | (state_d == EMC_ACCESS)))
                       ? ~(8'h01 << area_next) : 8'hff;

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state_q        <= EMC_IDLE;
         ext_q          <= 1'b0;
         area_q         <= '0;
         o_cs_n         <= 8'hff;
         o_first_access <= 1'b0;
         o_acc_done     <= 1'b0;
         o_acc_reject   <= 1'b0;
         o_bus_width    <= WIDTH_8;
         o_page_rom     <= 1'b0;
         o_bus_clk_en   <= 1'b1;
         o_clk_half     <= 1'b0;
      end else begin
         state_q        <= state_d;
         ext_q          <= ext_next;
         area_q         <= area_next;
         o_cs_n         <= cs_n_d;  // R15 R16
         o_first_access <= (state_d == EMC_ACCESS);
         o_acc_done     <= (state_q == EMC_ACCESS) & (state_d == EMC_END);
         o_acc_reject   <= refuse;
         o_bus_clk_en   <= ~lp_next;  // R6 R7
         o_clk_half     <= mode_q[CLK_SEL_POS];
         if (go) begin
            o_bus_width <= sel_wid;
            o_page_rom  <= sel_rom & ~i_acc_internal;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [15:0] lo_prev_q;
   always_ff @(posedge i_mclk) begin
      lo_prev_q <= cfg_lo_q;
   end

   a_lp_enter_type: assert property (@(posedge i_mclk) disable iff (i_srst)  // R6
      lp_enter |=> ((cfg_lo_q & TYPE_BITS) == 16'h0000) && ((cfg_hi_q & TYPE_BITS) == 16'h0000))
      else $error("type bits not cleared on low power entry");
   a_lp_enter_keep: assert property (@(posedge i_mclk) disable iff (i_srst)  // R6
      lp_enter && !wr_cfg_lo |=> (cfg_lo_q & EN_BITS) == ($past(cfg_lo_q) & EN_BITS))
      else $error("enable bits changed on low power entry");
   a_lp_exit_zero: assert property (@(posedge i_mclk) disable iff (i_srst)  // R7
      lp_exit && $past(lp_enter, 1) == 1'b0 && ((cfg_lo_q | cfg_hi_q) & ~TYPE_BITS & ~EN_BITS) == 16'h0000
      ##0 (((cfg_lo_q | cfg_hi_q) & TYPE_BITS) == 16'h0000) |=> cfg_lo_q == 16'h0000 && cfg_hi_q == 16'h0000)
      else $error("config registers not zero after low power exit");
   a_lp_clock_off: assert property (@(posedge i_mclk) disable iff (i_srst)  // R6
      lp_enter |=> !o_bus_clk_en ##1 (!o_bus_clk_en || $past(lp_exit)))
      else $error("bus clock not stopped in low power");
   a_lp_cs_idle: assert property (@(posedge i_mclk) disable iff (i_srst)  // R15
      lp_now |=> o_cs_n == 8'hff && !o_first_access)
      else $error("memory outputs active in low power");
   a_disabled_refused: assert property (@(posedge i_mclk) disable iff (i_srst)  // R16
      take && !i_acc_internal && !sel_en |=> o_acc_reject ##1 o_cs_n == 8'hff)
      else $error("disabled area not refused");
   a_setup_length: assert property (@(posedge i_mclk) disable iff (i_srst || lp_now)  // R9
      go && waits == 2'h3 |=> state_q == EMC_SETUP [*3] ##1 state_q == EMC_ACCESS)
      else $error("setup wait count wrong");
   a_setup_no_stall: assert property (@(posedge i_mclk) disable iff (i_srst || lp_now)  // R12
      state_q == EMC_SETUP && cnt_last |=> state_q == EMC_ACCESS)
      else $error("stall pin honoured during setup");
   a_internal_nowait: assert property (@(posedge i_mclk) disable iff (i_srst || lp_now)  // R13
      go && i_acc_internal |=> state_q == EMC_ACCESS && o_cs_n == 8'hff)
      else $error("internal access got setup waits");
   a_reset_setup: assert property (@(posedge i_mclk)  // R11
      $past(i_srst) |-> setup_q == SETUP_WAIT_RST && cfg_lo_q == AREA_CFG_RST)
      else $error("setup register reset value wrong");

   c_setup_path: cover property (@(posedge i_mclk) disable iff (i_srst)
      state_q == EMC_SETUP ##1 state_q == EMC_ACCESS ##1 o_acc_done);
   c_reject: cover property (@(posedge i_mclk) disable iff (i_srst) o_acc_reject);
   c_lp_cycle: cover property (@(posedge i_mclk) disable iff (i_srst) lp_enter ##[1:20] lp_exit);

endmodule

/* File: tb/emc_ext_dev.sv */
// model of the external devices behind the chip selects, drives the stall pin
// assumes the controller's chip selects and first access flag as registered outputs
`timescale 1ns/1ps
module emc_ext_dev (
   input  wire logic       i_mclk,         // memory interface clock
   input  wire logic       i_srst,         // synchronous reset, high
   input  wire logic [7:0] i_cs_n,         // chip selects, low active
   input  wire logic       i_first_access, // controller in first access state
   input  wire logic [3:0] i_stall_len,    // access cycles to keep stalling
   output logic            o_stall_pin     // stall request, high = stall
);
   logic [3:0] left_q;

   // unselected devices leave the pin floating, so it toggles every cycle;
   // a selected device stalls all through setup, which the controller must ignore
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         left_q      <= 4'h0;
         o_stall_pin <= 1'b0;
      end else if (&i_cs_n) begin
         left_q      <= i_stall_len;
         o_stall_pin <= ~o_stall_pin;
      end else if (!i_first_access) begin
         o_stall_pin <= 1'b1;
      end else if (left_q != 4'h0) begin
         left_q      <= left_q - 4'h1;
         o_stall_pin <= 1'b1;
      end else begin
         o_stall_pin <= 1'b0;
      end
   end
endmodule

/* File: tb/emc_area_cfg_tb_top.sv */
// self-checking bench for the area configuration block
// assumes zero-wait ahb-lite slave and the external device model beside it
`timescale 1ns/1ps
module emc_area_cfg_tb_top;
   import emc_pkg::*;
   logic        i_mclk, i_srst, i_hsel, i_hwrite, o_hreadyout, o_hresp, i_hready;
   logic [31:0] i_haddr, i_hwdata, o_hrdata;
   logic [1:0]  i_htrans, o_bus_width;
   logic        i_acc_req, i_acc_internal, i_acc_io, i_stall_pin;
   logic [2:0]  i_acc_area;
   logic [7:0]  o_cs_n;
   logic        o_first_access, o_acc_done, o_acc_reject, o_page_rom, o_bus_clk_en, o_clk_half;
   logic [3:0]  stall_len;
   int          num_errors, checks;
   logic [15:0] setup_val, width_val, cfg_val;

   assign i_hready = o_hreadyout;

   emc_area_cfg i_emc_area_cfg (.i_mclk(i_mclk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(i_hready),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_acc_req(i_acc_req),
      .i_acc_area(i_acc_area), .i_acc_internal(i_acc_internal), .i_acc_io(i_acc_io),
      .i_stall_pin(i_stall_pin), .o_cs_n(o_cs_n), .o_first_access(o_first_access), .o_acc_done(o_acc_done),
      .o_acc_reject(o_acc_reject), .o_bus_width(o_bus_width), .o_page_rom(o_page_rom),
      .o_bus_clk_en(o_bus_clk_en), .o_clk_half(o_clk_half));

   emc_ext_dev i_emc_ext_dev (.i_mclk(i_mclk), .i_srst(i_srst), .i_cs_n(o_cs_n),
      .i_first_access(o_first_access), .i_stall_len(stall_len), .o_stall_pin(i_stall_pin));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_mclk);
      i_hsel   <= 1'b1;
      i_haddr  <= idx << ADDR_SHIFT;
      i_htrans <= HTRANS_NONSEQ;
      i_hwrite <= wr;
      @(posedge i_mclk);
      while (i_hready !== 1'b1) @(posedge i_mclk);
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      @(posedge i_mclk);
      while (i_hready !== 1'b1) @(posedge i_mclk);
      rd = o_hrdata;
      check({31'h0, o_hresp}, 32'h0, "response not okay");
      i_hsel   <= 1'b0;
      i_hwrite <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] idx, input logic [15:0] d);
      logic [31:0] x;
      ahb(1'b1, idx, {16'h0, d}, x);
   endtask

   task automatic rdc(input logic [31:0] idx, input logic [15:0] exp, input string msg);
      logic [31:0] x;
      ahb(1'b0, idx, 32'h0, x);
      check(x, {16'h0, exp}, msg);
   endtask

   // one access; fields and timing judged only where the access is accepted
   task automatic acc(input logic [2:0] a, input logic intl, input logic io, input int waits,
                      input logic rej, input int min_done);
      int k;
      logic [7:0] cs_exp;
      cs_exp = (rej || intl) ? 8'hff : ~(8'h01 << a);
      @(posedge i_mclk);
      i_acc_req      <= 1'b1;
      i_acc_area     <= a;
      i_acc_internal <= intl;
      i_acc_io       <= io;
      k = 0;
      // the request is taken at the first edge of the loop, so outputs are judged from that edge on
      do begin
         @(posedge i_mclk);
         if (k == 0) i_acc_req <= 1'b0;
         #1;
         k++;
         if (k == 1) check({24'h0, o_cs_n}, {24'h0, cs_exp}, "chip selects");
      end while (o_first_access !== 1'b1 && o_acc_reject !== 1'b1 && k < 20);
      check({31'h0, o_acc_reject}, {31'h0, rej}, "reject");
      if (!rej) begin
         check(k, waits + 1, "setup waits");
         if (!intl) check({30'h0, o_bus_width}, {30'h0, width_val[2*a +: 2]}, "bus width");
         if (!intl) check({31'h0, o_page_rom}, {31'h0, cfg_val[4*(a%4)]}, "device type");
         k = 0;
         while (o_acc_done !== 1'b1 && k < 40) begin
            @(posedge i_mclk);
            #1;
            k++;
         end
         check({31'h0, o_acc_done}, 32'h1, "access done");
         check({31'h0, k > min_done}, 32'h1, "stall honoured");
         check({24'h0, o_cs_n}, 32'hff, "chip selects released");
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      rdc(IDX_AREA_CFG_LO, 16'h0000, "cfg lo reset");
      rdc(IDX_AREA_CFG_HI, 16'h0000, "cfg hi reset");
      rdc(IDX_SETUP_WAIT, 16'hffff, "setup reset");
      rdc(IDX_BUS_WIDTH, 16'haaaa, "width reset");
      rdc(IDX_BUS_MODE, 16'h0000, "mode reset");
      rdc(32'hfffff4a0, 16'h0000, "unmapped read");
      check({31'h0, o_bus_clk_en}, 32'h1, "bus clock at reset");
   endtask

   task automatic t_config();
      wr(IDX_AREA_CFG_LO, 16'hffff);
      rdc(IDX_AREA_CFG_LO, 16'h9999, "reserved bits");
      cfg_val = 16'h8989;
      wr(IDX_AREA_CFG_LO, cfg_val);
      wr(IDX_AREA_CFG_HI, 16'h1898);
      rdc(IDX_AREA_CFG_LO, 16'h8989, "cfg lo");
      rdc(IDX_AREA_CFG_HI, 16'h1898, "cfg hi");
      width_val = 16'haaaa;
      stall_len = 4'h4;
      acc(3'h0, 1'b0, 1'b0, 3, 1'b0, 4);
   endtask

   task automatic t_setup_waits();
      int fld;
      setup_val = 16'h1be4;
      width_val = 16'h24e4;
      wr(IDX_SETUP_WAIT, setup_val);
      wr(IDX_BUS_WIDTH, width_val);
      rdc(IDX_SETUP_WAIT, setup_val, "setup readback");
      rdc(IDX_BUS_WIDTH, width_val, "width readback");
      for (int a = 0; a < 7; a++) begin
         cfg_val = (a < 4) ? 16'h8989 : 16'h1898;
         fld = setup_val[2*a +: 2];
         acc(a[2:0], 1'b0, 1'b0, fld, 1'b0, (fld == 3) ? 4 : 0);
      end
      acc(3'h7, 1'b0, 1'b0, 0, 1'b1, 0);
      acc(3'h3, 1'b1, 1'b0, 0, 1'b0, 0);
      cfg_val = 16'h8989;
      acc(3'h3, 1'b0, 1'b1, 0, 1'b0, 0);
   endtask

   task automatic t_low_power();
      wr(IDX_BUS_MODE, 16'h0005);
      rdc(IDX_BUS_MODE, 16'h0005, "mode readback");
      check({31'h0, o_clk_half}, 32'h1, "clock select");
      check({31'h0, o_bus_clk_en}, 32'h0, "bus clock stopped");
      rdc(IDX_AREA_CFG_LO, 16'h8888, "types cleared lo");
      rdc(IDX_AREA_CFG_HI, 16'h0888, "types cleared hi");
      acc(3'h1, 1'b0, 1'b0, 0, 1'b1, 0);
      wr(IDX_BUS_MODE, 16'h0000);
      rdc(IDX_AREA_CFG_LO, 16'h0000, "enables cleared lo");
      rdc(IDX_AREA_CFG_HI, 16'h0000, "enables cleared hi");
      check({31'h0, o_bus_clk_en}, 32'h1, "bus clock restarted");
      acc(3'h1, 1'b0, 1'b0, 0, 1'b1, 0);
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #(40 * 6000);
      num_errors++;
      wrap_up();
   end

   initial begin
      i_srst = 1'b1;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'h0;
      i_hwrite = 1'b0;
      i_hwdata = 32'h0;
      i_acc_req = 1'b0;
      i_acc_area = 3'h0;
      i_acc_internal = 1'b0;
      i_acc_io = 1'b0;
      stall_len = 4'h0;
      num_errors = 0;
      checks = 0;
      repeat (5) @(posedge i_mclk);
      i_srst <= 1'b0;
      t_reset_values();
      t_config();
      t_setup_waits();
      t_low_power();
      wrap_up();
   end
endmodule
